// file: rtl/psv_pkg.sv
// Constants shared by the port supervisor: timing, addresses, register map, states.
package psv_pkg;
    localparam int NPORT = 4;
    localparam int CNT_W = 24;
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int CYC_PER_US = SYS_CLK_HZ / 1_000_000;
    // Abnormal switch condition must persist this long (least time, rounded up)
    localparam int SW_FAULT_NS = 180_000;
    localparam int SW_FAULT_CYC = (SW_FAULT_NS * CYC_PER_US + 999) / 1000;
    // Low-priority shed deadline (longest time, rounded down)
    localparam int SHED_MAX_NS = 6_500;
    localparam int SHED_MAX_CYC = (SHED_MAX_NS * CYC_PER_US) / 1000;
    // Least spacing between two shed turn-offs (rounded up)
    localparam int SHED_GAP_NS = 550;
    localparam int SHED_GAP_CYC = (SHED_GAP_NS * CYC_PER_US + 999) / 1000;
    localparam int SLOW_SPS = 14;
    localparam int FAST_SPS = 440;
    localparam int DISC_TIMEOUT_MS = 300;
    localparam int START_TIMEOUT_MS = 60;
    localparam logic [15:0] FAST_MASK = 16'hffe0;
    // Serial addresses
    localparam logic [2:0] ADDR_PRI_HI = 3'h2;
    localparam logic [6:0] ADDR_BCAST = 7'h30;
    localparam logic [6:0] ADDR_ARA = 7'h0c;
    // Register offsets
    localparam logic [7:0] REG_POWER = 8'h00;
    localparam logic [7:0] REG_DETCLS = 8'h01;
    localparam logic [7:0] REG_DISC_EN = 8'h02;
    localparam logic [7:0] REG_PRIO = 8'h03;
    localparam logic [7:0] REG_ALERT_MASK = 8'h04;
    localparam logic [7:0] REG_EVENT = 8'h05;
    localparam logic [7:0] REG_SWFAULT = 8'h06;
    localparam logic [7:0] REG_CONFIG = 8'h07;
    localparam logic [7:0] REG_ILIM_BASE = 8'h10;
    localparam logic [7:0] REG_FOLD_BASE = 8'h14;
    localparam logic [7:0] REG_MEAS_BASE = 8'h20;
    // Reset values
    localparam logic [7:0] DISC_EN_RST = 8'h0f;
    localparam logic [7:0] DETCLS_RST = 8'h00;
    localparam logic [7:0] ILIM_RST = 8'h80;
    localparam logic [7:0] FOLD_RST = 8'h00;
    localparam int CFG_FAST_BIT = 0;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_AACK = 7'h04,
        ST_RX = 7'h08,
        ST_RACK = 7'h10,
        ST_TX = 7'h20,
        ST_TACK = 7'h40
    } psv_i2c_st_t;
endpackage

// file: rtl/psv_port_supervisor.sv
// Four-port power supervisor: faults, disconnect, shutdown, shedding, readback, serial slave.
`timescale 1ns/100ps

module psv_port_supervisor
    import psv_pkg::*;
#(
    parameter int DISC_CYC = DISC_TIMEOUT_MS * (SYS_CLK_HZ / 1000),
    parameter int START_CYC = START_TIMEOUT_MS * (SYS_CLK_HZ / 1000),
    parameter int SLOW_CYC = SYS_CLK_HZ / SLOW_SPS,
    parameter int FAST_CYC = SYS_CLK_HZ / FAST_SPS
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [3:0] i_port_off_pin_n,
    input wire logic i_priority_shed_pin_n,
    input wire logic [3:0] i_address_select_pins,
    input wire logic i_scl,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_alert_in,
    output logic o_alert_out,
    output logic o_alert_oe,
    input wire logic [3:0] i_sense_high,
    input wire logic [3:0] i_gate_high,
    input wire logic [3:0] i_out_on_sensed,
    input wire logic [3:0] i_undercurrent,
    input wire logic [3:0] i_inrush_done,
    input wire logic [63:0] i_meas_volt,
    input wire logic [63:0] i_meas_curr,
    output logic [3:0] o_port_on,
    output logic [3:0] o_gate_weak,
    output logic [3:0] o_det_en,
    output logic [3:0] o_cls_en,
    output logic [31:0] o_ilim_cfg,
    output logic [31:0] o_fold_cfg
);
    localparam int NA = 31;
    localparam int SHED_BOUND = SHED_MAX_CYC;
    // Idle pin levels, so the edge detectors see no false edge after reset
    localparam logic [NA-1:0] SYNC_IDLE = {3'h7, 4'hf, 24'h000000};

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    // Same-word block of four per-port registers
    function automatic logic in_quad(input logic [7:0] a, input logic [7:0] base);
        in_quad = (a[7:2] == base[7:2]);
    endfunction

    logic [NA-1:0] sync1_ff, sync2_ff;
    logic scl_s, sda_s, shed_n_s, scl_d_ff, sda_d_ff;
    logic [3:0] off_n_s, adsel_s, sense_s, gate_s, onsn_s, uc_s, idone_s;
    logic [3:0] power_ff, sw_fault_ff, disc_evt_ff, inr_evt_ff, det_ff, cls_ff;
    logic [3:0] sw_set, dis_set, st_set, shed_hit, port_rst, pend;
    logic [7:0] dcac_ff, prio_ff, mask_ff, rd_mux, sh_ff;
    logic [7:0] ilim_ff [NPORT];
    logic [7:0] fold_ff [NPORT];
    logic [15:0] volt_ff [NPORT];
    logic [15:0] curr_ff [NPORT];
    logic fast_cfg_ff, mode_cur_ff, alert_ff, sda_oe_ff, ara_ff, conv_tick;
    logic [CNT_W-1:0] conv_cnt_ff;
    logic [3:0] gap_ff, bit_ff;
    psv_i2c_st_t i2c_st_ff;

    // Pins and comparator outputs all come from outside this clock
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sync1_ff <= SYNC_IDLE;
            sync2_ff <= SYNC_IDLE;
        end else if (i_ce) begin
            sync1_ff <= {i_scl, i_sda_in, i_priority_shed_pin_n, i_port_off_pin_n,
                         i_address_select_pins, i_sense_high, i_gate_high,
                         i_out_on_sensed, i_undercurrent, i_inrush_done};
            sync2_ff <= sync1_ff;
        end
    end
    assign {scl_s, sda_s, shed_n_s, off_n_s, adsel_s, sense_s, gate_s, onsn_s,
            uc_s, idone_s} = sync2_ff;

    assign port_rst = (i_ce && i_wr && i_addr == REG_SWFAULT) ? i_wdata[3:0] : 4'h0;

    // Shared configuration registers
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            dcac_ff <= DISC_EN_RST;
            prio_ff <= 8'h00;
            mask_ff <= 8'h00;
            fast_cfg_ff <= 1'b0;
        end else if (i_ce && i_wr) begin
            if (i_addr == REG_DISC_EN) dcac_ff <= i_wdata;
            if (i_addr == REG_PRIO) prio_ff <= i_wdata;
            if (i_addr == REG_ALERT_MASK) mask_ff <= i_wdata;
            if (i_addr == REG_CONFIG) fast_cfg_ff <= i_wdata[CFG_FAST_BIT];
        end
    end

    // Conversion pacing; mode latched only at a conversion boundary
    assign conv_tick = (conv_cnt_ff == '0);
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            conv_cnt_ff <= '0;
            mode_cur_ff <= 1'b0;
        end else if (i_ce) begin
            if (conv_tick) begin
                mode_cur_ff <= fast_cfg_ff;
                conv_cnt_ff <= fast_cfg_ff ? CNT_W'(FAST_CYC - 1) : CNT_W'(SLOW_CYC - 1);
            end else begin
                conv_cnt_ff <= conv_cnt_ff - 1'b1;
            end
        end
    end
    a_mode_hold: assert property (i_ce && !conv_tick |=> $stable(mode_cur_ff))
        else $error("conversion mode changed mid conversion");

    // Staggered shedding: lowest pending port first, one per gap
    assign pend = {4{~shed_n_s}} & prio_ff[3:0] & power_ff;
    assign shed_hit = (gap_ff == 4'h0) ? (pend & (~pend + 4'h1)) : 4'h0;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            gap_ff <= 4'h0;
        end else if (i_ce) begin
            if (|shed_hit) gap_ff <= 4'(SHED_GAP_CYC - 1);
            else if (gap_ff != 4'h0) gap_ff <= gap_ff - 4'h1;
        end
    end
    a_shed_gap: assert property (i_ce && (|shed_hit) |=> !(|shed_hit) [*5])
        else $error("shed events closer than the least gap");
    a_shed_bound: assert property (!shed_n_s && prio_ff[0] && power_ff[0]
        |-> ##[0:SHED_BOUND] !power_ff[0])
        else $error("low priority port not shed in time");

    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            logic abn, dis_on, st_on;
            logic [CNT_W-1:0] abn_cnt_ff, dis_cnt_ff, st_cnt_ff;
            assign abn = sense_s[p] | gate_s[p] | (onsn_s[p] & ~power_ff[p]);
            assign sw_set[p] = abn && abn_cnt_ff >= CNT_W'(SW_FAULT_CYC);
            assign dis_on = power_ff[p] & uc_s[p] & (dcac_ff[p] | dcac_ff[p+4]);
            assign dis_set[p] = dis_on && dis_cnt_ff == CNT_W'(DISC_CYC - 1);
            // Open switch never shows abnormal, so only the inrush timer catches it
            assign st_on = power_ff[p] & ~idone_s[p];
            assign st_set[p] = st_on && st_cnt_ff == CNT_W'(START_CYC - 1);

            always_ff @(posedge i_sys_clk) begin
                if (i_rst || port_rst[p]) begin
                    abn_cnt_ff <= '0;
                end else if (i_ce) begin
                    if (!abn) abn_cnt_ff <= '0;
                    else if (!sw_set[p]) abn_cnt_ff <= abn_cnt_ff + 1'b1;
                end
            end
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    dis_cnt_ff <= '0;
                    st_cnt_ff <= '0;
                end else if (i_ce) begin
                    dis_cnt_ff <= dis_on ? dis_cnt_ff + 1'b1 : '0;
                    st_cnt_ff <= st_on ? st_cnt_ff + 1'b1 : '0;
                end
            end
            // Set wins over clear for all hardware flags
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    sw_fault_ff[p] <= 1'b0;
                    disc_evt_ff[p] <= 1'b0;
                    inr_evt_ff[p] <= 1'b0;
                end else if (i_ce) begin
                    if (sw_set[p]) sw_fault_ff[p] <= 1'b1;
                    else if (port_rst[p]) sw_fault_ff[p] <= 1'b0;
                    if (dis_set[p]) disc_evt_ff[p] <= 1'b1;
                    else if (i_wr && i_addr == REG_EVENT && i_wdata[p]) disc_evt_ff[p] <= 1'b0;
                    if (st_set[p]) inr_evt_ff[p] <= 1'b1;
                    else if (i_wr && i_addr == REG_EVENT && i_wdata[p+4]) inr_evt_ff[p] <= 1'b0;
                end
            end
            // Turn-off causes win over a software enable in the same cycle
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    power_ff[p] <= 1'b0;
                end else if (i_ce) begin
                    if (sw_fault_ff[p] || sw_set[p] || !off_n_s[p] || shed_hit[p]
                        || dis_set[p] || st_set[p] || port_rst[p]) power_ff[p] <= 1'b0;
                    else if (i_wr && i_addr == REG_POWER) power_ff[p] <= i_wdata[p];
                end
            end
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    det_ff[p] <= DETCLS_RST[p];
                    cls_ff[p] <= DETCLS_RST[p+4];
                end else if (i_ce) begin
                    if (shed_hit[p]) begin
                        det_ff[p] <= 1'b0;
                        cls_ff[p] <= 1'b0;
                    end else if (i_wr && i_addr == REG_DETCLS) begin
                        det_ff[p] <= i_wdata[p];
                        cls_ff[p] <= i_wdata[p+4];
                    end
                end
            end
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    ilim_ff[p] <= ILIM_RST;
                    fold_ff[p] <= FOLD_RST;
                end else if (i_ce && i_wr && i_addr[1:0] == 2'(p)) begin
                    if (in_quad(i_addr, REG_ILIM_BASE)) ilim_ff[p] <= i_wdata;
                    if (in_quad(i_addr, REG_FOLD_BASE)) fold_ff[p] <= i_wdata;
                end
            end
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    volt_ff[p] <= 16'h0000;
                    curr_ff[p] <= 16'h0000;
                end else if (i_ce && conv_tick) begin
                    volt_ff[p] <= i_meas_volt[16*p +: 16] & (mode_cur_ff ? FAST_MASK : 16'hffff);
                    curr_ff[p] <= i_meas_curr[16*p +: 16] & (mode_cur_ff ? FAST_MASK : 16'hffff);
                end
            end
            assign o_ilim_cfg[8*p +: 8] = ilim_ff[p];
            assign o_fold_cfg[8*p +: 8] = fold_ff[p];

            a_swfault_off: assert property (sw_fault_ff[p] |-> !power_ff[p])
                else $error("port powered while switch fault latched");
            a_swfault_hold: assert property (sw_fault_ff[p] && !port_rst[p] |=> sw_fault_ff[p])
                else $error("switch fault cleared without port reset");
            a_disc_expire: assert property (i_ce && dis_set[p] |=> !power_ff[p] && disc_evt_ff[p])
                else $error("disconnect expiry did not turn port off");
            a_disc_restart: assert property (i_ce && !uc_s[p] |=> dis_cnt_ff == '0)
                else $error("disconnect timer not cleared on recovery");
            a_disc_disabled: assert property (i_ce && !dcac_ff[p] && !dcac_ff[p+4]
                |=> dis_cnt_ff == '0)
                else $error("disconnect timer ran while disabled");
            a_offpin_off: assert property (i_ce && !off_n_s[p] |=> !power_ff[p])
                else $error("port on while off pin low");
            a_shed_clear: assert property (i_ce && shed_hit[p] |=> !power_ff[p] && !det_ff[p])
                else $error("shed port kept power or detection");
            a_fast_zero: assert property (i_ce && conv_tick && mode_cur_ff
                |=> volt_ff[p][4:0] == 5'h00 && curr_ff[p][4:0] == 5'h00)
                else $error("fast mode low bits not zero");
        end
    endgenerate

    // Read mux; measurement readback of an unpowered port reads zero
    always_comb begin
        rd_mux = 8'h00;
        if (in_quad(i_addr, REG_ILIM_BASE)) rd_mux = ilim_ff[i_addr[1:0]];
        else if (in_quad(i_addr, REG_FOLD_BASE)) rd_mux = fold_ff[i_addr[1:0]];
        else if (i_addr[7:4] == REG_MEAS_BASE[7:4]) begin
            if (power_ff[i_addr[3:2]]) begin
                case (i_addr[1:0])
                    2'h0: rd_mux = volt_ff[i_addr[3:2]][7:0];
                    2'h1: rd_mux = volt_ff[i_addr[3:2]][15:8];
                    2'h2: rd_mux = curr_ff[i_addr[3:2]][7:0];
                    default: rd_mux = curr_ff[i_addr[3:2]][15:8];
                endcase
            end
        end else begin
            case (i_addr)
                REG_POWER: rd_mux = {4'h0, power_ff};
                REG_DETCLS: rd_mux = {cls_ff, det_ff};
                REG_DISC_EN: rd_mux = dcac_ff;
                REG_PRIO: rd_mux = prio_ff;
                REG_ALERT_MASK: rd_mux = mask_ff;
                REG_EVENT: rd_mux = {inr_evt_ff, disc_evt_ff};
                REG_SWFAULT: rd_mux = {4'h0, sw_fault_ff};
                REG_CONFIG: rd_mux = {6'h00, mode_cur_ff, fast_cfg_ff};
                default: rd_mux = 8'h00;
            endcase
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) o_rdata <= 8'h00;
        else if (i_ce && i_rd) o_rdata <= rd_mux;
    end

    // Alert: disconnects masked per port, inrush and switch faults sharing one mask bit per port, onto one line
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) alert_ff <= 1'b0;
        else if (i_ce) alert_ff <= |({inr_evt_ff | sw_fault_ff, disc_evt_ff} & mask_ff);
    end

    // Serial slave, oversampled from the system clock; never drives the clock
    logic scl_rise, scl_fall, start_c, stop_c, a_pri, a_bc, a_ara, hit;
    logic [6:0] my_addr;
    assign my_addr = {ADDR_PRI_HI, adsel_s};
    assign scl_rise = scl_s & ~scl_d_ff;
    assign scl_fall = ~scl_s & scl_d_ff;
    assign start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_c = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    assign a_pri = (sh_ff[7:1] == my_addr);
    assign a_bc = (sh_ff[7:1] == ADDR_BCAST) && !sh_ff[0];
    assign a_ara = (sh_ff[7:1] == ADDR_ARA) && sh_ff[0] && alert_ff;
    assign hit = a_pri | a_bc | a_ara;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else if (i_ce) begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            i2c_st_ff <= ST_IDLE;
            sh_ff <= 8'h00;
            bit_ff <= 4'h0;
            ara_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (i_ce) begin
            if (start_c) begin
                i2c_st_ff <= ST_ADDR;
                bit_ff <= 4'h0;
                sda_oe_ff <= 1'b0;
            end else if (stop_c) begin
                i2c_st_ff <= ST_IDLE;
                sda_oe_ff <= 1'b0;
            end else begin
                case (i2c_st_ff)
                    ST_IDLE: sda_oe_ff <= 1'b0;
                    ST_ADDR, ST_RX: begin
                        if (scl_rise) begin
                            sh_ff <= {sh_ff[6:0], sda_s};
                            bit_ff <= bit_ff + 4'h1;
                        end else if (scl_fall && bit_ff == 4'h8) begin
                            if (i2c_st_ff == ST_RX || hit) begin
                                sda_oe_ff <= 1'b1;
                                ara_ff <= (i2c_st_ff == ST_ADDR) && a_ara;
                                i2c_st_ff <= (i2c_st_ff == ST_RX) ? ST_RACK : ST_AACK;
                            end else begin
                                i2c_st_ff <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK, ST_RACK: begin
                        if (scl_fall) begin
                            bit_ff <= 4'h0;
                            if (i2c_st_ff == ST_AACK && ara_ff) begin
                                sh_ff <= {my_addr, 1'b0};
                                sda_oe_ff <= ~my_addr[6];
                                i2c_st_ff <= ST_TX;
                            end else begin
                                sda_oe_ff <= 1'b0;
                                i2c_st_ff <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_ff == 4'h7) begin
                                sda_oe_ff <= 1'b0;
                                i2c_st_ff <= ST_TACK;
                            end else begin
                                sh_ff <= {sh_ff[6:0], 1'b0};
                                sda_oe_ff <= ~sh_ff[6];
                                bit_ff <= bit_ff + 4'h1;
                            end
                        end
                    end
                    ST_TACK: if (scl_rise) i2c_st_ff <= ST_IDLE;
                    default: i2c_st_ff <= ST_IDLE;
                endcase
            end
        end
    end
    a_addr_ack: assert property (i_ce && i2c_st_ff == ST_ADDR && !start_c && !stop_c
        && scl_fall && bit_ff == 4'h8 && a_pri |=> sda_oe_ff && i2c_st_ff == ST_AACK)
        else $error("primary address not acknowledged");
    a_bcast_ack: assert property (i_ce && i2c_st_ff == ST_ADDR && !start_c && !stop_c
        && scl_fall && bit_ff == 4'h8 && a_bc |=> sda_oe_ff)
        else $error("broadcast address not acknowledged");
    a_ara_gate: assert property (i_ce && i2c_st_ff == ST_ADDR && !start_c && !stop_c
        && scl_fall && bit_ff == 4'h8 && !hit |=> i2c_st_ff == ST_IDLE && !sda_oe_ff)
        else $error("foreign or unalerted address acknowledged");

    assign o_sda_out = 1'b0;
    assign o_sda_oe = sda_oe_ff;
    assign o_alert_out = 1'b0;
    assign o_alert_oe = alert_ff;
    assign o_port_on = power_ff;
    assign o_gate_weak = sw_fault_ff;
    assign o_det_en = det_ff;
    assign o_cls_en = cls_ff;
endmodule

// file: tb/psv_host_model.sv
// Serial bus host model: one address byte, the acknowledge, then one data byte if a read is acknowledged.
`timescale 1ns/100ps
module psv_host_model (
    input wire logic i_sda_oe,
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // Master only; MSB first, 800 ns bits, clock parked high
    task automatic addr_byte(input logic [7:0] b, output logic ack, output logic [7:0] rb);
        o_sda = 1'b0;
        #400 o_scl = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #200 o_sda = b[i];
            #200 o_scl = 1'b1;
            #400 o_scl = 1'b0;
        end
        #200 o_sda = 1'b1;
        #200 o_scl = 1'b1;
        #200 ack = i_sda_oe;
        #200 o_scl = 1'b0;
        rb = 8'h00;
        if (b[0] && ack) begin
            // Read: SDA left released, sampled mid-high, then NACK
            for (int i = 7; i >= 0; i--) begin
                #400 o_scl = 1'b1;
                #200 rb[i] = ~i_sda_oe;
                #200 o_scl = 1'b0;
            end
            #400 o_scl = 1'b1;
            #400 o_scl = 1'b0;
        end
        #200 o_sda = 1'b0;
        #200 o_scl = 1'b1;
        #400 o_sda = 1'b1;
        #800;
    endtask
endmodule

// file: tb/psv_port_supervisor_tb.sv
// Self-checking bench for the port supervisor.
`timescale 1ns/100ps
module psv_port_supervisor_tb;
    import psv_pkg::*;
    logic i_sys_clk = 0, i_rst = 1, i_ce = 1, i_wr = 0, i_rd = 0, i_alert_in = 1;
    logic i_priority_shed_pin_n = 1, i_scl, i_sda_in, host_sda, o_sda_out, o_sda_oe;
    logic o_alert_out, o_alert_oe, ack;
    logic [7:0] i_addr = 0, i_wdata = 0, o_rdata, d;
    logic [3:0] i_port_off_pin_n = 4'hf, i_address_select_pins = 0, i_sense_high = 0;
    logic [3:0] i_gate_high = 0, i_out_on_sensed = 0, i_undercurrent = 0, i_inrush_done = 4'hf;
    logic [3:0] o_port_on, o_gate_weak, o_det_en, o_cls_en;
    logic [63:0] i_meas_volt = 0, i_meas_curr = 0;
    logic [31:0] o_ilim_cfg, o_fold_cfg, e;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    psv_port_supervisor #(.DISC_CYC(50), .START_CYC(40), .SLOW_CYC(30), .FAST_CYC(10)) dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_port_off_pin_n(i_port_off_pin_n),
        .i_priority_shed_pin_n(i_priority_shed_pin_n),
        .i_address_select_pins(i_address_select_pins), .i_scl(i_scl), .i_sda_in(i_sda_in),
        .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_alert_in(i_alert_in),
        .o_alert_out(o_alert_out), .o_alert_oe(o_alert_oe), .i_sense_high(i_sense_high),
        .i_gate_high(i_gate_high), .i_out_on_sensed(i_out_on_sensed),
        .i_undercurrent(i_undercurrent), .i_inrush_done(i_inrush_done),
        .i_meas_volt(i_meas_volt), .i_meas_curr(i_meas_curr), .o_port_on(o_port_on),
        .o_gate_weak(o_gate_weak), .o_det_en(o_det_en), .o_cls_en(o_cls_en),
        .o_ilim_cfg(o_ilim_cfg), .o_fold_cfg(o_fold_cfg));
    psv_host_model host (.i_sda_oe(o_sda_oe), .o_scl(i_scl), .o_sda(host_sda));
    // Open-drain wire: pulled up unless the host or the device sinks it
    assign i_sda_in = host_sda & ~o_sda_oe;
    initial forever #50 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] s, ex, input string n);
        checks_done++;
        if (s !== ex) begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", n, ex, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1;
        @(posedge i_sys_clk);
        i_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1;
        @(posedge i_sys_clk);
        i_rd <= 0;
        #1 d = o_rdata;
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hfb11));
        i_address_select_pins <= 4'($urandom);
        i_meas_volt <= {$urandom, $urandom};
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 0;
        chk(o_ilim_cfg, {4{ILIM_RST}}, "ilim reset");
        chk(o_fold_cfg, {4{FOLD_RST}}, "fold reset");
        chk({o_sda_out, o_alert_out}, 0, "open drain lows");
        rd(REG_DISC_EN);
        chk(d, DISC_EN_RST, "disc reset");
        for (int i = 0; i < 4; i++) begin
            e[8*i+:8] = 8'($urandom);
            wr(REG_ILIM_BASE + 8'(i), e[8*i+:8]);
        end
        rd(8'h3f);
        chk(d, 0, "unmapped");
        chk(o_ilim_cfg, e, "ilim");
        wr(REG_POWER, 8'h0f);
        @(posedge i_sys_clk) i_port_off_pin_n <= 4'he;
        cy(5);
        @(posedge i_sys_clk) i_port_off_pin_n <= 4'hf;
        cy(5);
        chk(o_port_on, 4'he, "off pin");
        @(posedge i_sys_clk) i_gate_high <= 4'h8;
        cy(SW_FAULT_CYC + 5);
        @(posedge i_sys_clk) i_gate_high <= 4'h0;
        chk(o_gate_weak, 4'h8, "switch fault");
        chk(o_port_on, 4'h6, "fault power");
        // Let the synchroniser drain, or the fault re-sets over the port reset
        cy(3);
        wr(REG_SWFAULT, 8'h08);
        cy(2);
        chk(o_gate_weak, 4'h0, "port reset");
        wr(REG_CONFIG, 8'h01);
        cy(45);
        rd(REG_MEAS_BASE + 8'h04);
        chk(d, i_meas_volt[23:16] & 8'he0, "fast lo");
        rd(REG_MEAS_BASE);
        chk(d, 0, "unpowered");
        $display("test config, pins, fault, readback done");
        wr(REG_DETCLS, 8'hff);
        wr(REG_PRIO, 8'h05);
        wr(REG_POWER, 8'h0f);
        @(posedge i_sys_clk) i_priority_shed_pin_n <= 0;
        cy(SHED_MAX_CYC);
        chk(o_port_on, 4'ha, "shed");
        chk({o_cls_en, o_det_en}, 8'haa, "shed enables");
        @(posedge i_sys_clk) i_priority_shed_pin_n <= 1;
        wr(REG_POWER, 8'h0f);
        wr(REG_DISC_EN, 8'h21);
        @(posedge i_sys_clk) i_undercurrent <= 4'h7;
        cy(40);
        @(posedge i_sys_clk) i_undercurrent <= 4'h0;
        cy(3);
        @(posedge i_sys_clk) i_undercurrent <= 4'h7;
        cy(40);
        chk(o_port_on, 4'hf, "recovery");
        cy(20);
        chk(o_port_on, 4'hc, "disconnect");
        @(posedge i_sys_clk) i_inrush_done <= 4'h7;
        cy(45);
        chk(o_port_on, 4'h4, "inrush off");
        chk(o_gate_weak, 4'h0, "no switch fault");
        rd(REG_EVENT);
        chk(d[3:0], 4'h3, "disc event");
        chk(d[7:4], 4'h8, "inrush event");
        $display("test shed, disconnect done");
        host.addr_byte({ADDR_PRI_HI, i_address_select_pins, 1'b0}, ack, d);
        chk(ack, 1, "primary");
        host.addr_byte({ADDR_BCAST, 1'b0}, ack, d);
        chk(ack, 1, "broadcast");
        host.addr_byte({ADDR_PRI_HI, ~i_address_select_pins, 1'b0}, ack, d);
        chk(ack, 0, "foreign");
        host.addr_byte({ADDR_ARA, 1'b1}, ack, d);
        chk(ack, 0, "ara quiet");
        wr(REG_ALERT_MASK, 8'h01);
        cy(3);
        chk(o_alert_oe, 1, "alert");
        host.addr_byte({ADDR_ARA, 1'b1}, ack, d);
        chk(ack, 1, "ara");
        chk(d, {ADDR_PRI_HI, i_address_select_pins, 1'b0}, "ara reply");
        $display("test serial done");
        print_verdict();
    end
endmodule
